//--- core/gauge_ctrl_regs.sv
// control, feature and flag registers of the fuel gauge
`timescale 1ns/1ps
`default_nettype none
module gauge_ctrl_regs
  import gauge_ctrl_pkg::*;
(
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // register port from the two-wire slave
  input  wire logic [7:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_we_i,
  output logic [7:0]      reg_rdata_o,
  // nonvolatile parameter memory
  output logic            nv_rd_req_o,
  input  wire logic       nv_rd_done_i,
  input  wire logic [7:0] nv_rd_data_i,
  input  wire logic       persist_cmd_i,
  output logic            nv_wr_o,
  output logic [7:0]      nv_wr_data_o,
  // measurement events
  input  wire logic       cell_voltage_reading_below_sleep_i,
  input  wire logic       vin_below_sleep_i,
  input  wire logic       cell_voltage_reading_below_empty_i,
  input  wire logic       acr_zero_i,
  input  wire logic       learn_set_i,
  input  wire logic       learn_clr_other_i,
  // bus lines as sensed
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  // general purpose pin
  input  wire logic       gp_pin_i,
  output logic            gp_pin_o,
  output logic            gp_pin_oe_o,
  // state
  output logic            sleep_o,
  output logic            ready_o,
  output logic [7:0]      slave_addr_o
);
  import gauge_ctrl_pkg::*;

  recall_state_e state_q;
  logic [7:0]    ctrl_q;
  logic          addr_we_q;
  logic          pin_ctrl_q;
  logic [7:0]    slave_addr_q;
  logic          below_empty_seen_q;
  logic          acr_zero_q;
  logic          sleep_q;
  logic          uv_flag;
  logic          por_flag;
  logic          learn_flag;
  logic          uv_cond;
  logic          idle_cond;
  logic          uv_done;
  logic          idle_done;
  logic          sleep_enter;
  logic          run;
  logic          wr_stat;
  logic          wr_ctrl;
  logic          wr_feat;
  logic          acr_hit;

  assign run     = (state_q == ST_RUN);
  assign wr_stat = run && reg_we_i && (reg_addr_i == ADDR_STATUS);
  assign wr_ctrl = run && reg_we_i && (reg_addr_i == ADDR_SLEEP_CTRL);
  assign wr_feat = run && reg_we_i && (reg_addr_i == ADDR_FEATURE);

  // power-up recall; host writes are held off until the shadow is valid
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= ST_LOAD_REQ;
    end else begin
      unique case (state_q)
        ST_LOAD_REQ:  state_q <= ST_LOAD_WAIT;
        ST_LOAD_WAIT: if (nv_rd_done_i) state_q <= ST_RUN;
        ST_RUN:       state_q <= ST_RUN;
        default:      state_q <= ST_LOAD_REQ;
      endcase
    end
  end

  assign nv_rd_req_o = (state_q == ST_LOAD_REQ);
  assign ready_o     = run;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= 8'h00;
    end else if (state_q == ST_LOAD_WAIT && nv_rd_done_i) begin
      ctrl_q <= nv_rd_data_i & CTRL_MASK;
    end else if (wr_ctrl) begin
      ctrl_q <= reg_wdata_i & CTRL_MASK;
    end
  end

  // persist only copies the shadow; the shadow itself is untouched
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      nv_wr_o      <= 1'b0;
      nv_wr_data_o <= 8'h00;
    end else begin
      nv_wr_o <= run && persist_cmd_i;
      if (run && persist_cmd_i) begin
        nv_wr_data_o <= ctrl_q;
      end
    end
  end

  // feature register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      addr_we_q <= ADDR_WE_RESET;
    end else if (wr_feat) begin
      addr_we_q <= reg_wdata_i[FEAT_ADDR_WE_BIT];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_ctrl_q <= PIN_CTRL_RESET;
    end else if (sleep_enter) begin
      pin_ctrl_q <= 1'b1;
    end else if (wr_feat) begin
      pin_ctrl_q <= reg_wdata_i[FEAT_PIN_BIT];
    end
  end

  // open drain: output level is always low, only the enable moves
  assign gp_pin_o    = 1'b0;
  assign gp_pin_oe_o = !pin_ctrl_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      slave_addr_q <= SLAVE_ADDR_RESET;
    end else if (run && reg_we_i && reg_addr_i == ADDR_SLAVE_ADDR && addr_we_q) begin
      slave_addr_q <= reg_wdata_i;
    end
  end
  assign slave_addr_o = slave_addr_q;

  // status flags
  flag_cell #(.RESET_VAL(1'b0)) u_uv_flag (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .set_i  (cell_voltage_reading_below_sleep_i),
    .clr_i  (wr_stat && !reg_wdata_i[STAT_UV_BIT]),
    .flag_o (uv_flag)
  );

  flag_cell #(.RESET_VAL(1'b1)) u_por_flag (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .set_i  (1'b0),
    .clr_i  (wr_stat && !reg_wdata_i[STAT_POR_BIT]),
    .flag_o (por_flag)
  );

  // remembers that voltage dropped below active empty before the count hit zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      below_empty_seen_q <= 1'b0;
      acr_zero_q         <= 1'b0;
    end else begin
      acr_zero_q <= acr_zero_i;
      if (cell_voltage_reading_below_empty_i) begin
        below_empty_seen_q <= 1'b1;
      end else if (acr_hit || learn_set_i) begin
        below_empty_seen_q <= 1'b0;
      end
    end
  end

  assign acr_hit = acr_zero_i && !acr_zero_q && below_empty_seen_q;

  flag_cell #(.RESET_VAL(1'b0)) u_learn_flag (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .set_i  (learn_set_i),
    .clr_i  (acr_hit || learn_clr_other_i || sleep_enter),
    .flag_o (learn_flag)
  );

  // sleep qualification
  assign uv_cond   = ctrl_q[CTRL_UV_BIT] && vin_below_sleep_i;
  assign idle_cond = ctrl_q[CTRL_IDLE_BIT] && !scl_i && !sda_i;

  idle_timer u_uv_timer (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .cond_i (run && uv_cond),
    .scl_i  (scl_i),
    .sda_i  (sda_i),
    .done_o (uv_done)
  );

  idle_timer u_idle_timer (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .cond_i (run && idle_cond),
    .scl_i  (scl_i),
    .sda_i  (sda_i),
    .done_o (idle_done)
  );

  assign sleep_enter = !sleep_q && (uv_done || idle_done);

  // bus activity wakes the device only with the bus-idle enable set and no under-voltage condition
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sleep_q <= 1'b0;
    end else if (sleep_enter) begin
      sleep_q <= 1'b1;
    end else if (scl_i || sda_i) begin
      sleep_q <= sleep_q && !(ctrl_q[CTRL_IDLE_BIT] && !uv_cond);
    end
  end
  assign sleep_o = sleep_q;

  // read data
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      reg_rdata_o <= 8'h00;
    end else begin
      unique case (reg_addr_i)
        ADDR_STATUS:     reg_rdata_o <= {3'h0, learn_flag, 1'b0, uv_flag, por_flag, 1'b0};
        ADDR_FEATURE:    reg_rdata_o <= {6'h00, addr_we_q, gp_pin_i};
        ADDR_SLEEP_CTRL: reg_rdata_o <= ctrl_q;
        ADDR_SLAVE_ADDR: reg_rdata_o <= slave_addr_q;
        default:         reg_rdata_o <= 8'h00;
      endcase
    end
  end

  // checks
  a_pin_follows_ctrl: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_feat && !sleep_enter |=> gp_pin_oe_o == !$past(reg_wdata_i[FEAT_PIN_BIT]))
    else $error("pin driver does not follow feature write");
  a_pin_sleep_release: assert property (@(posedge clk_i) disable iff (rst_i)
    sleep_enter |=> !gp_pin_oe_o)
    else $error("pin driven after sleep entry");
  a_addr_write_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    !addr_we_q |=> $stable(slave_addr_q))
    else $error("slave address changed while writes disabled");
  a_uv_flag_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
    uv_flag && !(wr_stat && !reg_wdata_i[STAT_UV_BIT]) |=> uv_flag)
    else $error("under-voltage flag cleared without host");
  a_por_flag_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
    por_flag && !wr_stat |=> por_flag)
    else $error("power-on flag cleared without host");
  a_ctrl_recall: assert property (@(posedge clk_i) disable iff (rst_i)
    state_q == ST_LOAD_WAIT && nv_rd_done_i |=> ctrl_q == ($past(nv_rd_data_i) & CTRL_MASK))
    else $error("control not recalled");
  a_persist_data: assert property (@(posedge clk_i) disable iff (rst_i)
    run && persist_cmd_i |=> nv_wr_o && nv_wr_data_o == $past(ctrl_q))
    else $error("persist did not store shadow");
  a_sleep_needs_enable: assert property (@(posedge clk_i) disable iff (rst_i)
    sleep_enter |-> ctrl_q[CTRL_UV_BIT] || ctrl_q[CTRL_IDLE_BIT])
    else $error("sleep entered with both enables off");
  a_learn_clear_cause: assert property (@(posedge clk_i) disable iff (rst_i)
    learn_flag && !learn_set_i && !learn_clr_other_i && !sleep_enter && !below_empty_seen_q
    |=> learn_flag)
    else $error("learn flag cleared by count without low voltage");
  a_pin_sense_read: assert property (@(posedge clk_i) disable iff (rst_i)
    reg_addr_i == ADDR_FEATURE |=> reg_rdata_o[0] == $past(gp_pin_i))
    else $error("pin sense not returned");
  a_ctrl_host_write: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_ctrl |=> ctrl_q == ($past(reg_wdata_i) & CTRL_MASK))
    else $error("control write not taken");
  // persist must leave the shadow alone, or a copy would race a host write
  a_persist_keeps_shadow: assert property (@(posedge clk_i) disable iff (rst_i)
    run && persist_cmd_i && !wr_ctrl |=> $stable(ctrl_q))
    else $error("shadow changed by persist");
  a_addr_write_taken: assert property (@(posedge clk_i) disable iff (rst_i)
    run && reg_we_i && reg_addr_i == ADDR_SLAVE_ADDR && addr_we_q
    |=> slave_addr_q == $past(reg_wdata_i))
    else $error("enabled slave address write lost");
  a_addr_we_write: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_feat |=> addr_we_q == $past(reg_wdata_i[FEAT_ADDR_WE_BIT]))
    else $error("address write enable not taken");
  a_sleep_pin_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    sleep_q && !gp_pin_oe_o && !wr_feat |=> !gp_pin_oe_o)
    else $error("pin driven during sleep without host write");

  c_sleep_idle: cover property (@(posedge clk_i) disable iff (rst_i) sleep_enter && idle_done);
  c_sleep_uv:   cover property (@(posedge clk_i) disable iff (rst_i) sleep_enter && uv_done);
  c_pin_low:    cover property (@(posedge clk_i) disable iff (rst_i) gp_pin_oe_o);
  c_learn_clr:  cover property (@(posedge clk_i) disable iff (rst_i) acr_hit && learn_flag);
  c_persist:    cover property (@(posedge clk_i) disable iff (rst_i) nv_wr_o);
endmodule
`default_nettype wire

//--- core/gauge_ctrl_pkg.sv
// constants for the gauge control and feature register block
package gauge_ctrl_pkg;
  // register addresses on the internal two-wire register port
  localparam logic [7:0] ADDR_STATUS       = 8'h01;
  localparam logic [7:0] ADDR_FEATURE      = 8'h15;
  localparam logic [7:0] ADDR_SLAVE_ADDR   = 8'h7E;
  localparam logic [7:0] ADDR_SLEEP_CTRL   = 8'h60;
  // field positions
  localparam int unsigned CTRL_UV_BIT      = 6;
  localparam int unsigned CTRL_IDLE_BIT    = 5;
  localparam int unsigned FEAT_ADDR_WE_BIT = 1;
  localparam int unsigned FEAT_PIN_BIT     = 0;
  localparam int unsigned STAT_LEARN_BIT   = 4;
  localparam int unsigned STAT_UV_BIT      = 2;
  localparam int unsigned STAT_POR_BIT     = 1;
  // writable bits of the control register
  localparam logic [7:0] CTRL_MASK         = 8'h60;
  // values after reset
  localparam logic [7:0] SLAVE_ADDR_RESET  = 8'h68;
  localparam logic       ADDR_WE_RESET     = 1'b0;
  localparam logic       PIN_CTRL_RESET    = 1'b1;
  // sleep qualifying time
  localparam int unsigned CLK_MHZ          = 100;
  localparam int unsigned SLEEP_QUALIFY_US = 40;
  localparam int unsigned SLEEP_QUALIFY_CYC = SLEEP_QUALIFY_US * CLK_MHZ;
  localparam int unsigned QCNT_W           = 16;
  // state of the power-up recall
  typedef enum logic [1:0] {
    ST_LOAD_REQ  = 2'h0,
    ST_LOAD_WAIT = 2'h1,
    ST_RUN       = 2'h3
  } recall_state_e;
endpackage

//--- core/flag_cell.sv
// sticky flag: hardware set wins over host clear
`timescale 1ns/1ps
`default_nettype none
module flag_cell #(
  parameter logic RESET_VAL = 1'b0
) (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // set and clear
  input  wire logic set_i,
  input  wire logic clr_i,
  // state
  output logic      flag_o
);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flag_o <= RESET_VAL;
    end else if (set_i) begin
      flag_o <= 1'b1;
    end else if (clr_i) begin
      flag_o <= 1'b0;
    end
  end
endmodule
`default_nettype wire

//--- core/idle_timer.sv
// qualifying-time counter that restarts on any change of the watched lines
`timescale 1ns/1ps
`default_nettype none
module idle_timer
  import gauge_ctrl_pkg::*;
(
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // condition and watched lines
  input  wire logic cond_i,
  input  wire logic scl_i,
  input  wire logic sda_i,
  // qualified
  output logic      done_o
);
  logic [QCNT_W-1:0] cnt_q;
  logic              scl_q;
  logic              sda_q;
  logic              moved;

  assign moved = (scl_i != scl_q) || (sda_i != sda_q);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_i;
      sda_q <= sda_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= '0;
    end else if (!cond_i || moved) begin
      cnt_q <= '0;
    end else if (cnt_q != QCNT_W'(SLEEP_QUALIFY_CYC)) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  assign done_o = cond_i && !moved && (cnt_q == QCNT_W'(SLEEP_QUALIFY_CYC));
endmodule
`default_nettype wire

//--- verif/nv_mem_model.sv
// behavioural nonvolatile parameter memory behind the recall and persist ports
`timescale 1ns/1ps
`default_nettype none
module nv_mem_model #(
  parameter logic [7:0]  INIT_VAL = 8'h9F,
  parameter int unsigned LATENCY  = 3
) (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // recall
  input  wire logic       rd_req_i,
  output logic            rd_done_o,
  output logic [7:0]      rd_data_o,
  // persist
  input  wire logic       wr_i,
  input  wire logic [7:0] wr_data_i,
  output logic [7:0]      image_o
);
  int unsigned wait_q;
  // image survives reset, as nonvolatile storage should
  initial begin
    image_o = INIT_VAL;
    wait_q = 0;
    rd_done_o = 1'b0;
    rd_data_o = ~INIT_VAL;
  end
  always @(posedge clk_i) begin
    rd_done_o <= 1'b0;
    // data lines outside a recall pulse invert every cycle, alternating between the last loaded value and its complement
    rd_data_o <= ~rd_data_o;
    if (wr_i) begin
      image_o <= wr_data_i;
    end
    if (rst_i) begin
      wait_q <= 0;
    end else if (rd_req_i) begin
      wait_q <= LATENCY;
    end else if (wait_q == 1) begin
      rd_done_o <= 1'b1;
      rd_data_o <= image_o;
      wait_q <= 0;
    end else if (wait_q != 0) begin
      wait_q <= wait_q - 1;
    end
  end
endmodule
`default_nettype wire

//--- verif/tb_gauge_ctrl_regs.sv
// register-port testbench of the gauge control and feature registers
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin n_tests++; if ((a) !== (e)) begin errors++; \
  $display("Error %s exp %0h got %0h", n, e, a); end end
module tb_gauge_ctrl_regs;
  import gauge_ctrl_pkg::*;
  logic       clk_i = 1'b0;
  logic       rst_i = 1'b1;
  logic [7:0] reg_addr_i = 8'h00;
  logic [7:0] reg_wdata_i = 8'h00;
  logic       reg_we_i = 1'b0;
  logic [7:0] reg_rdata_o;
  logic       nv_rd_req_o, nv_rd_done_i, persist_cmd_i = 1'b0, nv_wr_o;
  logic [7:0] nv_rd_data_i, nv_wr_data_o, image, slave_addr_o, rv;
  logic       vs = 1'b0, sensed_input_voltage = 1'b0, ve = 1'b0, az = 1'b0, ls = 1'b0;
  logic       scl_i = 1'b1, sda_i = 1'b1, pin_ext = 1'b1;
  logic       gp_pin_o, gp_pin_oe_o, sleep_o, ready_o;
  wire        gp_pin_i = gp_pin_oe_o ? gp_pin_o : pin_ext;
  int         errors = 0, n_tests = 0, cyc = 0;
  gauge_ctrl_regs dut_u (.clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i), .reg_rdata_o(reg_rdata_o),
    .nv_rd_req_o(nv_rd_req_o), .nv_rd_done_i(nv_rd_done_i), .nv_rd_data_i(nv_rd_data_i),
    .persist_cmd_i(persist_cmd_i), .nv_wr_o(nv_wr_o), .nv_wr_data_o(nv_wr_data_o),
    .cell_voltage_reading_below_sleep_i(vs), .vin_below_sleep_i(sensed_input_voltage), .cell_voltage_reading_below_empty_i(ve),
    .acr_zero_i(az), .learn_set_i(ls), .learn_clr_other_i(1'b0), .scl_i(scl_i),
    .sda_i(sda_i), .gp_pin_i(gp_pin_i), .gp_pin_o(gp_pin_o), .gp_pin_oe_o(gp_pin_oe_o),
    .sleep_o(sleep_o), .ready_o(ready_o), .slave_addr_o(slave_addr_o));
  // recalled byte has the bus-idle enable set, so a missed recall shows
  localparam logic [7:0] NV_INIT = 8'hA5;
  nv_mem_model #(.INIT_VAL(NV_INIT)) nv_u (.clk_i(clk_i), .rst_i(rst_i),
    .rd_req_i(nv_rd_req_o), .rd_done_o(nv_rd_done_i), .rd_data_o(nv_rd_data_i), .wr_i(nv_wr_o),
    .wr_data_i(nv_wr_data_o), .image_o(image));
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  // whole run is near 20000 cycles
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 40000) begin
      errors++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("tests %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic do_reset();
    rst_i <= 1'b1;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 50 && ready_o !== 1'b1; i++) @(posedge clk_i);
    `CHK("ready", 1'b1, ready_o)
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_we_i <= 1'b1;
    @(posedge clk_i);
    reg_we_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge clk_i);
    reg_addr_i <= a;
    repeat (2) @(posedge clk_i);
    // read at the edge: holds what the previous edge launched
    rv = reg_rdata_o & m;
    `CHK("rdata", e, rv)
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  initial begin
    do_reset();
    rchk(ADDR_SLEEP_CTRL, 8'hFF, NV_INIT & CTRL_MASK);
    rchk(ADDR_STATUS, 8'h16, 8'h02);
    rchk(ADDR_FEATURE, 8'hFF, 8'h01);
    `CHK("oe", 1'b0, gp_pin_oe_o)
    $display("test reset done");
    wr(ADDR_SLAVE_ADDR, 8'h55);
    `CHK("saddr", 8'h68, slave_addr_o)
    wr(ADDR_FEATURE, 8'h03);
    wr(ADDR_SLAVE_ADDR, 8'h55);
    `CHK("saddr", 8'h55, slave_addr_o)
    wr(ADDR_FEATURE, 8'h02);
    `CHK("oe", 1'b1, gp_pin_oe_o)
    rchk(ADDR_FEATURE, 8'hFF, 8'h02);
    wr(ADDR_FEATURE, 8'h01);
    `CHK("oe", 1'b0, gp_pin_oe_o)
    rchk(ADDR_FEATURE, 8'hFF, 8'h01);
    pin_ext <= 1'b0;
    rchk(ADDR_FEATURE, 8'hFF, 8'h00);
    $display("test feature done");
    vs <= 1'b1;
    idle(2);
    vs <= 1'b0;
    rchk(ADDR_STATUS, 8'h06, 8'h06);
    wr(ADDR_STATUS, 8'hFF);
    rchk(ADDR_STATUS, 8'h06, 8'h06);
    wr(ADDR_STATUS, 8'h00);
    rchk(ADDR_STATUS, 8'h06, 8'h00);
    ls <= 1'b1;
    idle(1);
    ls <= 1'b0;
    az <= 1'b1;
    idle(2);
    az <= 1'b0;
    rchk(ADDR_STATUS, 8'h10, 8'h10);
    ve <= 1'b1;
    idle(2);
    az <= 1'b1;
    rchk(ADDR_STATUS, 8'h10, 8'h00);
    $display("test flags done");
    wr(ADDR_FEATURE, 8'h00);
    wr(ADDR_SLEEP_CTRL, 8'h20);
    scl_i <= 1'b0;
    sda_i <= 1'b0;
    idle(3000);
    scl_i <= 1'b1;
    idle(1);
    scl_i <= 1'b0;
    idle(3900);
    `CHK("sleep", 1'b0, sleep_o)
    idle(300);
    `CHK("sleep", 1'b1, sleep_o)
    `CHK("oe", 1'b0, gp_pin_oe_o)
    scl_i <= 1'b1;
    idle(5);
    `CHK("sleep", 1'b0, sleep_o)
    wr(ADDR_SLEEP_CTRL, 8'h00);
    scl_i <= 1'b0;
    idle(4200);
    `CHK("sleep", 1'b0, sleep_o)
    scl_i <= 1'b1;
    sda_i <= 1'b1;
    sensed_input_voltage <= 1'b1;
    idle(4200);
    `CHK("sleep", 1'b0, sleep_o)
    wr(ADDR_SLEEP_CTRL, 8'h40);
    idle(4200);
    `CHK("sleep", 1'b1, sleep_o)
    $display("test sleep done");
    sensed_input_voltage <= 1'b0;
    do_reset();
    wr(ADDR_SLEEP_CTRL, 8'h40);
    rchk(ADDR_SLEEP_CTRL, 8'hFF, 8'h40);
    `CHK("image", NV_INIT, image)
    persist_cmd_i <= 1'b1;
    idle(1);
    persist_cmd_i <= 1'b0;
    idle(3);
    `CHK("image", 8'h40, image)
    do_reset();
    rchk(ADDR_SLEEP_CTRL, 8'hFF, 8'h40);
    $display("test persist done");
    wrap_up();
  end
endmodule
`default_nettype wire
